// ==== core/mba_boot_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module mba_boot_ctrl
   import mba_pkg::*;
#(
   parameter int INIT_WAIT = MBA_INIT_WAIT_CYC,
   parameter int START_WAIT = MBA_START_WAIT_CYC,
   parameter int COUNT_WAIT = MBA_COUNT_WAIT_CYC
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   // User orders
   input wire logic START,
   input wire logic [7:0] START_VECTOR,
   input wire logic [7:0] ERROR_VECTOR,
   input wire logic OLDER_VARIANT,
   // Observation of the cores (asynchronous pins)
   input wire logic SELFTEST_DONE,
   input wire logic BUS_NOT_READY_LINE,
   input wire logic FINAL_BOOT_SEEN,
   // Register access to the bootstrap core
   output logic REG_REQ,
   output logic REG_WE,
   output logic [31:0] REG_ADDR,
   output logic [31:0] REG_WDATA,
   input wire logic REG_ACK,
   input wire logic [31:0] REG_RDATA,
   // Shared memory variables
   input wire logic [31:0] COUNT_VALUE,
   output logic COUNT_WE,
   output logic LOCK_WE,
   output logic [31:0] SHARED_WDATA,
   // Status
   output logic IRQ_INHIBIT,
   output logic BUSY,
   output logic DONE,
   output logic NO_SECONDARY,
   output logic [7:0] SAVED_BOOT_IDENTIFIER,
   output logic [31:0] START_ADDR
);
   logic rst_s1, rst_s2, rst_n;
   logic st_s1, st_s2, bnr_s1, bnr_s2, fb_s1, fb_s2;
   mba_state_t state;
   logic started;
   logic start_round;
   logic [31:0] hold;
   logic tmr_load;
   logic [MBA_TMR_W-1:0] tmr_count;
   logic tmr_exp;
   logic elected;

   // ****************
   // Reset and pin synchronisers
   // ****************
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_s2 <= rst_s1;
      end
   end
   assign rst_n = rst_s2;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         st_s1 <= 1'b0;
         st_s2 <= 1'b0;
         bnr_s1 <= 1'b0;
         bnr_s2 <= 1'b0;
         fb_s1 <= 1'b0;
         fb_s2 <= 1'b0;
      end else if (CE) begin
         st_s1 <= SELFTEST_DONE;
         st_s2 <= st_s1;
         bnr_s1 <= BUS_NOT_READY_LINE;
         bnr_s2 <= bnr_s1;
         fb_s1 <= FINAL_BOOT_SEEN;
         fb_s2 <= fb_s1;
      end
   end

   // ****************
   // Election watch
   // ****************
   // election runs once after reset only
   mba_elect u_elect (
      .clk(CLK),
      .rst_n(rst_n),
      .ce(CE),
      .selftest_done(st_s2),
      .bus_not_ready_line(bnr_s2),
      .older_variant(OLDER_VARIANT),
      .final_boot_seen(fb_s2),
      .elected(elected),
      .bus_quiet()
   );

   // ****************
   // Delay timer
   // ****************
   mba_timer #(.W(MBA_TMR_W)) u_timer (
      .clk(CLK),
      .rst_n(rst_n),
      .ce(CE),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_exp)
   );

   always_comb begin
      tmr_load = 1'b0;
      tmr_count = '0;
      if (state == MBA_WR_INIT && REG_ACK) begin
         tmr_load = 1'b1;
         tmr_count = MBA_TMR_W'(INIT_WAIT - 1);
      end else if (state == MBA_WR_START && REG_ACK) begin
         tmr_load = 1'b1;
         tmr_count = MBA_TMR_W'(START_WAIT - 1);
      end else if (state == MBA_WAIT_START && tmr_exp && started) begin
         tmr_load = 1'b1;
         tmr_count = MBA_TMR_W'(COUNT_WAIT - 1);
      end
   end

   // ****************
   // Wake sequence
   // ****************
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= MBA_IDLE;
         started <= 1'b0;
         hold <= '0;
         SAVED_BOOT_IDENTIFIER <= 8'h00;
         NO_SECONDARY <= 1'b0;
         DONE <= 1'b0;
      end else if (CE) begin
         case (state)
            MBA_IDLE: begin
               if (START && elected) begin
                  DONE <= 1'b0;
                  NO_SECONDARY <= 1'b0;
                  started <= 1'b0;
                  state <= MBA_RD_ID;
               end
            end
            MBA_RD_ID: begin
               if (REG_ACK) begin
                  SAVED_BOOT_IDENTIFIER <= 8'((REG_RDATA & MBA_ID_MASK) >> MBA_ID_LSB);
                  state <= MBA_RD_SVR;
               end
            end
            MBA_RD_SVR: begin
               if (REG_ACK) begin
                  hold <= REG_RDATA;
                  state <= MBA_WR_SVR;
               end
            end
            MBA_WR_SVR: if (REG_ACK) state <= MBA_RD_ERR;
            MBA_RD_ERR: begin
               if (REG_ACK) begin
                  hold <= REG_RDATA;
                  state <= MBA_WR_ERR;
               end
            end
            MBA_WR_ERR: if (REG_ACK) state <= MBA_WR_LOCK;
            MBA_WR_LOCK: state <= MBA_WR_COUNT;
            MBA_WR_COUNT: state <= MBA_WR_INIT;
            MBA_WR_INIT: if (REG_ACK) state <= MBA_WAIT_INIT;
            MBA_WAIT_INIT: if (tmr_exp) state <= MBA_WR_START;
            MBA_WR_START: if (REG_ACK) state <= MBA_WAIT_START;
            MBA_WAIT_START: begin
               if (tmr_exp) begin
                  if (started) begin
                     state <= MBA_WAIT_COUNT;
                  end else begin
                     started <= 1'b1;
                     state <= MBA_WR_START;
                  end
               end
            end
            MBA_WAIT_COUNT: if (tmr_exp) state <= MBA_RD_COUNT;
            MBA_RD_COUNT: begin
               NO_SECONDARY <= (COUNT_VALUE == MBA_COUNT_START);
               DONE <= 1'b1;
               state <= MBA_DONE;
            end
            MBA_DONE: state <= MBA_DONE;
            default: state <= MBA_IDLE;
         endcase
      end
   end

   assign start_round = started;

   // ****************
   // Register and memory drive
   // ****************
   always_comb begin
      REG_REQ = 1'b0;
      REG_WE = 1'b0;
      REG_ADDR = '0;
      REG_WDATA = '0;
      case (state)
         MBA_RD_ID: begin
            REG_REQ = 1'b1;
            REG_ADDR = MBA_ADDR_ID;
         end
         MBA_RD_SVR: begin
            REG_REQ = 1'b1;
            REG_ADDR = MBA_ADDR_SVR;
         end
         MBA_WR_SVR: begin
            REG_REQ = 1'b1;
            REG_WE = 1'b1;
            REG_ADDR = MBA_ADDR_SVR;
            REG_WDATA = hold | MBA_ENABLE_BIT;
         end
         MBA_RD_ERR: begin
            REG_REQ = 1'b1;
            REG_ADDR = MBA_ADDR_ERR;
         end
         MBA_WR_ERR: begin
            REG_REQ = 1'b1;
            REG_WE = 1'b1;
            REG_ADDR = MBA_ADDR_ERR;
            REG_WDATA = mba_set_low(hold, ERROR_VECTOR);
         end
         MBA_WR_INIT: begin
            REG_REQ = 1'b1;
            REG_WE = 1'b1;
            REG_ADDR = MBA_ADDR_CMD;
            REG_WDATA = MBA_CMD_INIT;
         end
         MBA_WR_START: begin
            REG_REQ = 1'b1;
            REG_WE = 1'b1;
            REG_ADDR = MBA_ADDR_CMD;
            REG_WDATA = mba_set_low(MBA_CMD_START, START_VECTOR);
         end
         default: begin
            REG_REQ = 1'b0;
         end
      endcase
   end

   assign LOCK_WE = (state == MBA_WR_LOCK) && CE;
   assign COUNT_WE = (state == MBA_WR_COUNT) && CE;
   assign SHARED_WDATA = (state == MBA_WR_COUNT) ? MBA_COUNT_START : MBA_LOCK_FREE;
   // interrupts held off during election and during wake, not in idle between
   assign IRQ_INHIBIT = !elected || (state != MBA_IDLE && state != MBA_DONE) || (start_round && !DONE);
   assign BUSY = (state != MBA_IDLE) && (state != MBA_DONE);
   // page vector to address bits 19:12
   assign START_ADDR = mba_start_addr(START_VECTOR);
endmodule : mba_boot_ctrl
`default_nettype wire

// ==== core/mba_elect.sv ====
`timescale 1ns/1ps
`default_nettype none
module mba_elect
   import mba_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Synchronised observation of the cores
   input wire logic selftest_done,
   input wire logic bus_not_ready_line,
   input wire logic older_variant,
   input wire logic final_boot_seen,
   // Result
   output logic elected,
   output logic bus_quiet
);
   mba_elect_t state;
   logic last_bnr;
   logic [3:0] quiet_cnt;

   // wait self test, watch toggling, older variant ends on final broadcast
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= MBA_EL_SELFTEST;
         last_bnr <= 1'b0;
         quiet_cnt <= 4'h0;
      end else if (ce) begin
         last_bnr <= bus_not_ready_line;
         case (state)
            MBA_EL_SELFTEST: begin
               if (selftest_done) begin
                  state <= MBA_EL_WATCH;
               end
            end
            MBA_EL_WATCH: begin
               if (bus_not_ready_line != last_bnr) begin
                  quiet_cnt <= 4'h0;
               end else if (quiet_cnt != 4'(MBA_QUIET_CYC)) begin
                  quiet_cnt <= quiet_cnt + 4'h1;
               end
               if (older_variant ? final_boot_seen : (quiet_cnt == 4'(MBA_QUIET_CYC))) begin
                  state <= MBA_EL_DONE;
               end
            end
            default: state <= MBA_EL_DONE;
         endcase
      end
   end

   assign elected = (state == MBA_EL_DONE);
   assign bus_quiet = (state == MBA_EL_WATCH) && (quiet_cnt == 4'(MBA_QUIET_CYC));
endmodule : mba_elect
`default_nettype wire

// ==== core/mba_pkg.sv ====
// How it works
// - Interrupt sources stay inhibited during the election and during the wake sequence, not in the idle state between them.
// - Secondaries race for semaphore, bump processor counter, then halt.
// - Controller enabled by setting bit 8 of spurious vector register; reads 0 after reset.
// - Error vector entry gets 8-bit handler vector in low byte, others kept.
// - Bootstrap writes broadcast-init command, then waits about 10 ms.
// - Bootstrap writes broadcast-startup with page vector twice, each followed by 200 us.
// - Counter set to 1, 100 ms timer; unchanged counter means no secondaries.
// - Lock semaphore set to free value zero before starting secondaries.
// - Identifier taken from top byte of identifier register by masking.
// - Secondary startup code sits in a 4 KB page below 1 MB; vector is page number.
package mba_pkg;
   localparam logic [31:0] MBA_ADDR_ID = 32'hFEE00020;
   localparam logic [31:0] MBA_ADDR_SVR = 32'hFEE000F0;
   localparam logic [31:0] MBA_ADDR_CMD = 32'hFEE00300;
   localparam logic [31:0] MBA_ADDR_ERR = 32'hFEE00370;
   localparam logic [31:0] MBA_ENABLE_BIT = 32'h00000100;
   localparam logic [31:0] MBA_ID_MASK = 32'hFF000000;
   localparam logic [31:0] MBA_LOW_BYTE_MASK = 32'hFFFFFF00;
   localparam logic [31:0] MBA_CMD_INIT = 32'h000C4500;
   localparam logic [31:0] MBA_CMD_START = 32'h000C4600;
   localparam logic [31:0] MBA_COUNT_START = 32'h00000001;
   localparam logic [31:0] MBA_LOCK_FREE = 32'h00000000;
   localparam int MBA_ID_LSB = 24;
   localparam int MBA_CLK_HZ = 10000000;
   localparam int MBA_INIT_WAIT_US = 10000;
   localparam int MBA_START_WAIT_US = 200;
   localparam int MBA_COUNT_WAIT_US = 100000;
   // Cycles at the bus clock; longest-time rounding down is exact here
   localparam int MBA_INIT_WAIT_CYC = MBA_INIT_WAIT_US * (MBA_CLK_HZ / 1000000);
   localparam int MBA_START_WAIT_CYC = MBA_START_WAIT_US * (MBA_CLK_HZ / 1000000);
   localparam int MBA_COUNT_WAIT_CYC = MBA_COUNT_WAIT_US * (MBA_CLK_HZ / 1000000);
   localparam int MBA_TMR_W = 20;
   localparam int MBA_QUIET_CYC = 8;

   typedef enum logic [3:0] {
      MBA_IDLE = 4'h0,
      MBA_RD_ID = 4'h1,
      MBA_RD_SVR = 4'h2,
      MBA_WR_SVR = 4'h3,
      MBA_RD_ERR = 4'h4,
      MBA_WR_ERR = 4'h5,
      MBA_WR_LOCK = 4'h6,
      MBA_WR_COUNT = 4'h7,
      MBA_WR_INIT = 4'h8,
      MBA_WAIT_INIT = 4'h9,
      MBA_WR_START = 4'hA,
      MBA_WAIT_START = 4'hB,
      MBA_WAIT_COUNT = 4'hC,
      MBA_RD_COUNT = 4'hD,
      MBA_DONE = 4'hE
   } mba_state_t;

   typedef enum logic [1:0] {
      MBA_EL_SELFTEST = 2'h0,
      MBA_EL_WATCH = 2'h1,
      MBA_EL_DONE = 2'h2
   } mba_elect_t;

   // Startup address: vector in bits 19:12, all else zero
   function automatic logic [31:0] mba_start_addr(input logic [7:0] vec);
      mba_start_addr = {12'h000, vec, 12'h000};
   endfunction : mba_start_addr

   // Replace the low byte, keep the rest
   function automatic logic [31:0] mba_set_low(input logic [31:0] word, input logic [7:0] vec);
      mba_set_low = (word & MBA_LOW_BYTE_MASK) | {24'h000000, vec};
   endfunction : mba_set_low
endpackage : mba_pkg

// ==== core/mba_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module mba_timer
   import mba_pkg::*;
#(
   parameter int W = MBA_TMR_W
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic expired
);
   logic [W-1:0] remain;
   logic running;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         remain <= '0;
         running <= 1'b0;
      end else if (ce) begin
         if (load) begin
            remain <= count;
            running <= 1'b1;
         end else if (running && remain != '0) begin
            remain <= remain - 1'b1;
         end else begin
            running <= 1'b0;
         end
      end
   end

   // Expiry must not look at load: the caller derives load from expiry
   assign expired = running && (remain == '0);
endmodule : mba_timer
`default_nettype wire

// ==== tb/mba_boot_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mba_boot_ctrl_chk
   import mba_pkg::*;
#(
   parameter int INIT_WAIT = 4,
   parameter int START_WAIT = 3,
   parameter int COUNT_WAIT = 5
) (
   // Clock, reset and orders
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] START_VECTOR,
   input wire logic [7:0] ERROR_VECTOR,
   // Register access
   input wire logic REG_REQ,
   input wire logic REG_WE,
   input wire logic [31:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_ACK,
   input wire logic [31:0] REG_RDATA,
   // Shared memory and status
   input wire logic [31:0] COUNT_VALUE,
   input wire logic COUNT_WE,
   input wire logic LOCK_WE,
   input wire logic [31:0] SHARED_WDATA,
   input wire logic IRQ_INHIBIT,
   input wire logic BUSY,
   input wire logic DONE,
   input wire logic NO_SECONDARY,
   input wire logic [7:0] SAVED_BOOT_IDENTIFIER,
   input wire logic [31:0] START_ADDR
);
   // ****
   // Helpers: cycles since last answer, last command, identifier read
   // ****
   logic [7:0] seen_id;
   logic last_init;
   int gap;
   wire logic cmd_wr = REG_REQ && REG_WE && REG_ADDR == MBA_ADDR_CMD;
   wire logic took = REG_REQ && REG_ACK;
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         seen_id <= 8'h00;
         last_init <= 1'h0;
         gap <= 0;
      end else begin
         gap <= took ? 0 : gap + 1;
         if (took && cmd_wr) begin
            last_init <= REG_WDATA == MBA_CMD_INIT;
         end
         if (took && !REG_WE && REG_ADDR == MBA_ADDR_ID) begin
            seen_id <= REG_RDATA[31:24];
         end
      end
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   AST_REQ_HOLD: assert property (REG_REQ && !REG_ACK |=> REG_REQ && $stable(REG_ADDR) && $stable(REG_WDATA))
      else $error("request changed before answer");
   AST_IRQ_OFF: assert property (BUSY |-> IRQ_INHIBIT)
      else $error("interrupts not inhibited while busy");
   AST_CMD_CODE: assert property (cmd_wr |-> REG_WDATA == MBA_CMD_INIT || REG_WDATA == {24'h000C46, START_VECTOR})
      else $error("bad command word");
   AST_SVR_EN: assert property (REG_REQ && REG_WE && REG_ADDR == MBA_ADDR_SVR |-> REG_WDATA[8])
      else $error("enable bit not set");
   AST_ERR_VEC: assert property (REG_REQ && REG_WE && REG_ADDR == MBA_ADDR_ERR |-> REG_WDATA[7:0] == ERROR_VECTOR)
      else $error("error vector wrong");
   AST_START_GAP: assert property ($rose(REG_REQ) && cmd_wr |-> last_init ? gap >= INIT_WAIT : gap >= START_WAIT - 1)
      else $error("startup sent too early");
   AST_COUNT_GAP: assert property ($rose(DONE) |-> gap >= START_WAIT + COUNT_WAIT)
      else $error("counter sampled too early");
   AST_RESULT: assert property ($rose(DONE) |-> NO_SECONDARY == (COUNT_VALUE == MBA_COUNT_START) && SAVED_BOOT_IDENTIFIER == seen_id)
      else $error("result flags wrong");
   AST_ADDR: assert property (DONE |-> START_ADDR == {12'h000, START_VECTOR, 12'h000})
      else $error("startup address wrong");
   AST_ONE_RUN: assert property (DONE |=> DONE && !REG_REQ)
      else $error("activity after run");
   AST_SHARED: assert property (LOCK_WE || COUNT_WE |-> SHARED_WDATA == (COUNT_WE ? MBA_COUNT_START : MBA_LOCK_FREE))
      else $error("shared value wrong");
   cover property ($rose(DONE) && NO_SECONDARY);
   cover property ($rose(DONE) && !NO_SECONDARY);
   cover property ($rose(REG_REQ) && cmd_wr && last_init);
endmodule : mba_boot_ctrl_chk
bind mba_boot_ctrl mba_boot_ctrl_chk #(.INIT_WAIT(INIT_WAIT), .START_WAIT(START_WAIT), .COUNT_WAIT(COUNT_WAIT)) i_chk (
   .CLK(CLK), .RST_N(RST_N), .START_VECTOR(START_VECTOR), .ERROR_VECTOR(ERROR_VECTOR), .REG_REQ(REG_REQ),
   .REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .REG_RDATA(REG_RDATA),
   .COUNT_VALUE(COUNT_VALUE), .COUNT_WE(COUNT_WE), .LOCK_WE(LOCK_WE), .SHARED_WDATA(SHARED_WDATA),
   .IRQ_INHIBIT(IRQ_INHIBIT), .BUSY(BUSY), .DONE(DONE), .NO_SECONDARY(NO_SECONDARY), .SAVED_BOOT_IDENTIFIER(SAVED_BOOT_IDENTIFIER),
   .START_ADDR(START_ADDR));
`default_nettype wire

// ==== tb/mba_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module mba_core_model
   import mba_pkg::*;
#(
   parameter logic [31:0] ID_RESET = 32'h03000000
) (
   // Clock and scenario
   input wire logic clk,
   input wire logic rst_n,
   input wire logic older,
   input wire logic sec_present,
   // Register port
   input wire logic req,
   input wire logic we,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   output logic ack,
   output logic [31:0] rdata,
   // Shared counter and pins
   input wire logic count_we,
   input wire logic [31:0] shared_wdata,
   output logic [31:0] count,
   output logic selftest_done,
   output logic bnr,
   output logic final_boot
);
   // ****
   // Bootstrap core registers and its peers
   // ****
   logic [31:0] id_reg, svr_reg, err_reg;
   logic [1:0] lat, wt;
   logic started;
   int tick;
   // register table, varying latency; data scrambled when idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         id_reg <= ID_RESET;
         svr_reg <= 32'h000000FF;
         err_reg <= 32'h00010000;
         ack <= 1'h0;
         rdata <= 32'h0;
         wt <= 2'h0;
         lat <= 2'h0;
      end else if (ack || !req) begin
         ack <= 1'h0;
         rdata <= ~rdata;
      end else if (wt != lat) begin
         wt <= wt + 2'h1;
      end else begin
         ack <= 1'h1;
         wt <= 2'h0;
         lat <= lat + 2'h1;
         rdata <= addr == MBA_ADDR_ID ? id_reg : addr == MBA_ADDR_SVR ? svr_reg : err_reg;
         if (we && addr == MBA_ADDR_ID) id_reg <= wdata;
         if (we && addr == MBA_ADDR_SVR) svr_reg <= wdata;
         if (we && addr == MBA_ADDR_ERR) err_reg <= wdata;
      end
   end
   // self test, bus settling, one count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 0;
         bnr <= 1'h0;
         count <= 32'hFFFFFFFF;
         started <= 1'h0;
      end else begin
         tick <= tick + 1;
         if (tick < 30) bnr <= ~bnr;
         if (count_we) count <= shared_wdata;
         if (req && ack && we && addr == MBA_ADDR_CMD && wdata[15:8] == 8'h46) begin
            started <= 1'h1;
            if (!started && sec_present) count <= count + 32'h2;
         end
      end
   end
   assign selftest_done = tick >= 10;
   // final broadcast only in the older scheme
   assign final_boot = older && tick >= 40;
endmodule : mba_core_model
`default_nettype wire

// ==== tb/test_mba_boot_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_mba_boot_ctrl;
   import mba_pkg::*;
   localparam logic [31:0] ID_VAL = 32'h03000000;
   logic CLK, RST_N, CE, START, OLDER_VARIANT, sec_present, done_q;
   logic SELFTEST_DONE, BUS_NOT_READY_LINE, FINAL_BOOT_SEEN, REG_REQ, REG_WE, REG_ACK, COUNT_WE, LOCK_WE;
   logic IRQ_INHIBIT, BUSY, DONE, NO_SECONDARY;
   logic [7:0] START_VECTOR, ERROR_VECTOR, SAVED_BOOT_IDENTIFIER;
   logic [31:0] REG_ADDR, REG_WDATA, REG_RDATA, COUNT_VALUE, SHARED_WDATA, START_ADDR, lfsr;
   logic [65:0] exp_q[$];
   int n_fail, tests_run;
   mba_boot_ctrl #(.INIT_WAIT(4), .START_WAIT(3), .COUNT_WAIT(5)) i_dut (
      .CLK(CLK), .RST_N(RST_N), .CE(CE), .START(START), .START_VECTOR(START_VECTOR), .ERROR_VECTOR(ERROR_VECTOR),
      .OLDER_VARIANT(OLDER_VARIANT), .SELFTEST_DONE(SELFTEST_DONE), .BUS_NOT_READY_LINE(BUS_NOT_READY_LINE),
      .FINAL_BOOT_SEEN(FINAL_BOOT_SEEN), .REG_REQ(REG_REQ), .REG_WE(REG_WE), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_ACK(REG_ACK), .REG_RDATA(REG_RDATA), .COUNT_VALUE(COUNT_VALUE),
      .COUNT_WE(COUNT_WE), .LOCK_WE(LOCK_WE), .SHARED_WDATA(SHARED_WDATA), .IRQ_INHIBIT(IRQ_INHIBIT), .BUSY(BUSY),
      .DONE(DONE), .NO_SECONDARY(NO_SECONDARY), .SAVED_BOOT_IDENTIFIER(SAVED_BOOT_IDENTIFIER), .START_ADDR(START_ADDR));
   mba_core_model #(.ID_RESET(ID_VAL)) i_core (
      .clk(CLK), .rst_n(RST_N), .older(OLDER_VARIANT), .sec_present(sec_present), .req(REG_REQ), .we(REG_WE),
      .addr(REG_ADDR), .wdata(REG_WDATA), .ack(REG_ACK), .rdata(REG_RDATA), .count_we(COUNT_WE),
      .shared_wdata(SHARED_WDATA), .count(COUNT_VALUE), .selftest_done(SELFTEST_DONE), .bnr(BUS_NOT_READY_LINE),
      .final_boot(FINAL_BOOT_SEEN));
   // ****
   // Shared tasks
   // ****
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next
   task automatic check(input string what, input logic [65:0] seen, input logic [65:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic take(input logic [65:0] seen);
      if (exp_q.size() == 0) begin
         n_fail++;
         $display("ERROR bus event expected none seen %h", seen);
      end else begin
         check("bus event", seen, exp_q.pop_front());
      end
   endtask : take
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report
   // One run per reset; START is held from reset so an early start must be refused
   task automatic run(input logic older, input logic sec, input logic abort);
      int k;
      logic [32:0] frozen;
      RST_N = 1'h0;
      START = 1'h1;
      OLDER_VARIANT = older;
      sec_present = sec;
      lfsr = lfsr_next(lfsr);
      START_VECTOR = lfsr[7:0];
      ERROR_VECTOR = lfsr[15:8];
      exp_q.delete();
      repeat (3) @(negedge CLK);
      RST_N = 1'h1;
      exp_q.push_back({2'h0, MBA_ADDR_ID, 32'h0});
      exp_q.push_back({2'h0, MBA_ADDR_SVR, 32'h0});
      exp_q.push_back({2'h1, MBA_ADDR_SVR, 32'h000001FF});
      exp_q.push_back({2'h0, MBA_ADDR_ERR, 32'h0});
      exp_q.push_back({2'h1, MBA_ADDR_ERR, 24'h000100, ERROR_VECTOR});
      exp_q.push_back({2'h2, 32'h0, 32'h0});
      exp_q.push_back({2'h2, 32'h1, 32'h1});
      exp_q.push_back({2'h1, MBA_ADDR_CMD, MBA_CMD_INIT});
      repeat (2) exp_q.push_back({2'h1, MBA_ADDR_CMD, 24'h000C46, START_VECTOR});
      exp_q.push_back({2'h3, 12'h000, START_VECTOR, 12'h000, 23'h0, ~sec, ID_VAL[31:24]});
      k = 0;
      while (BUSY !== 1'h1 && k < 500) begin
         @(negedge CLK);
         k++;
      end
      check("election wait", {65'h0, k >= 38 && k < 500}, 66'h1);
      START = 1'h0;
      if (abort) begin
         repeat (3) @(negedge CLK);
         // Clock enable low must freeze the sequence mid-access
         CE = 1'h0;
         frozen = {REG_WE, REG_ADDR};
         repeat (4) @(negedge CLK);
         check("frozen access", {33'h0, REG_WE, REG_ADDR}, {33'h0, frozen});
         CE = 1'h1;
         repeat (2) @(negedge CLK);
         RST_N = 1'h0;
         exp_q.delete();
         @(negedge CLK);
         check("reset idle", {63'h0, REG_REQ, BUSY, IRQ_INHIBIT}, 66'h1);
      end else begin
         k = 0;
         while (DONE !== 1'h1 && k < 500) begin
            @(negedge CLK);
            k++;
         end
         START = 1'h1;
         repeat (2) @(negedge CLK);
         START = 1'h0;
         repeat (20) @(negedge CLK);
         check("second start", {64'h0, REG_REQ, DONE}, 66'h1);
         check("events left", 66'(exp_q.size()), 66'h0);
      end
      $display("run older=%0d sec=%0d abort=%0d done", older, sec, abort);
   endtask : run
   // ****
   // Clock, monitor, watchdog, sequence
   // ****
   initial begin
      CLK = 1'h0;
      forever #50 CLK = ~CLK;
   end
   always @(negedge CLK) begin
      if (RST_N === 1'h1 && CE === 1'h1) begin
         if (REG_REQ && REG_ACK) take({1'h0, REG_WE, REG_ADDR, REG_WE ? REG_WDATA : 32'h0});
         if (LOCK_WE || COUNT_WE) take({2'h2, 31'h0, COUNT_WE, SHARED_WDATA});
         if (DONE && !done_q) take({2'h3, START_ADDR, 23'h0, NO_SECONDARY, SAVED_BOOT_IDENTIFIER});
      end
      done_q = DONE;
   end
   initial begin
      repeat (5000) @(posedge CLK);
      n_fail++;
      $display("ERROR watchdog expected finish seen timeout");
      final_report();
   end
   initial begin
      n_fail = 0;
      tests_run = 0;
      lfsr = 32'hAF2885B3;
      CE = 1'h1;
      done_q = 1'h0;
      run(1'h0, 1'h1, 1'h0);
      run(1'h1, 1'h0, 1'h0);
      run(1'h0, 1'h1, 1'h1);
      run(1'h1, 1'h1, 1'h0);
      final_report();
   end
endmodule : test_mba_boot_ctrl
`default_nettype wire
